/* File: design/tmsc_cfg.svh */
// Constants for the terminal mode and schedule controller.
`ifndef TMSC_CFG_SVH
`define TMSC_CFG_SVH
`define TMSC_CLK_HZ         25000000
`define TMSC_SEL_WAIT_MS    2500
`define TMSC_SEL_WAIT_CYC   ((`TMSC_CLK_HZ / 1000) * `TMSC_SEL_WAIT_MS)
`define TMSC_REVERT_S       5
`define TMSC_REVERT_CYC     (`TMSC_CLK_HZ * `TMSC_REVERT_S)
`define TMSC_SHOW_MS        1000
`define TMSC_SHOW_CYC       ((`TMSC_CLK_HZ / 1000) * `TMSC_SHOW_MS)
`define TMSC_BELL_S         5
`define TMSC_BEEP_MS        100
`define TMSC_BEEP_CYC       ((`TMSC_CLK_HZ / 1000) * `TMSC_BEEP_MS)
`define TMSC_ADDR_MAX       8'h0a
`define TMSC_ADDR_RESET     8'h00
`define TMSC_ENTRIES        32
`define TMSC_DAYS           7
`endif

/* File: design/tmsc_pkg.sv */
// Types for the terminal mode and schedule controller.
package tmsc_pkg;
  typedef enum logic [4:0] {
    ST_POWERUP = 5'h01,
    ST_WAIT    = 5'h02,
    ST_ADDRSET = 5'h04,
    ST_NORMAL  = 5'h08,
    ST_FWMGMT  = 5'h10
  } tmsc_state_type;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
  } tmsc_time_type;

  typedef struct packed {
    logic          valid;
    tmsc_time_type at;
    logic          event_out;
  } tmsc_entry_type;
endpackage

/* File: design/tmsc_bell.sv */
// Bell schedule matcher and relay timer.
`timescale 1ns/10ps
`include "tmsc_cfg.svh"
module tmsc_bell #(
  parameter int ENTRIES   = `TMSC_ENTRIES,
  parameter int BELL_CYC  = `TMSC_CLK_HZ * `TMSC_BELL_S
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    week_mode,
  input  wire logic [2:0]              weekday,
  input  wire tmsc_pkg::tmsc_time_type now,
  input  wire logic                    day_start,
  input  wire logic [ENTRIES-1:0]      valid_tab [`TMSC_DAYS+1],
  input  wire tmsc_pkg::tmsc_time_type time_tab  [`TMSC_DAYS+1][ENTRIES],
  output logic                         relay_on
);
  logic [ENTRIES-1:0] fired_q;
  logic [31:0]        cnt_q;
  logic [2:0]         tab;
  logic [ENTRIES-1:0] hit;

  always_comb begin
    tab = week_mode ? weekday : 3'h7;
    for (int i = 0; i < ENTRIES; i++) begin
      hit[i] = valid_tab[tab][i] && time_tab[tab][i] == now && !fired_q[i];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fired_q <= '0;
    end else begin
      // A match in the day-start cycle still marks its entry, so it cannot fire twice.
      fired_q <= (day_start ? '0 : fired_q) | hit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
    end else if (|hit) begin
      cnt_q <= 32'(BELL_CYC);
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  assign relay_on = cnt_q != 32'h0;

  a_relay_fires: assert property (@(posedge clock) disable iff (!rst_n)
    |hit |=> relay_on) else $error("Relay not energised on match.");
  a_relay_ends: assert property (@(posedge clock) disable iff (!rst_n)
    (cnt_q == 32'h1 && !(|hit)) |=> !relay_on) else $error("Relay held too long.");
endmodule // tmsc_bell

/* File: design/tmsc_ctrl.sv */
// Terminal mode selection, address setting and schedule control.
`timescale 1ns/10ps
`include "tmsc_cfg.svh"
module tmsc_ctrl #(
  parameter int ENTRIES    = `TMSC_ENTRIES,
  parameter int SEL_CYC    = `TMSC_SEL_WAIT_CYC,
  parameter int REVERT_CYC = `TMSC_REVERT_CYC,
  parameter int SHOW_CYC   = `TMSC_SHOW_CYC,
  parameter int BEEP_CYC   = `TMSC_BEEP_CYC,
  parameter int BELL_CYC   = `TMSC_CLK_HZ * `TMSC_BELL_S
) (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    key_in,
  input  wire logic                    key_out,
  input  wire logic                    card_read,
  input  wire logic                    host_addr_we,
  input  wire logic [7:0]              host_addr,
  input  wire logic [7:0]              cmd_addr,
  input  wire tmsc_pkg::tmsc_time_type now,
  input  wire logic [2:0]              weekday,
  input  wire logic                    day_start,
  input  wire logic                    bell_week_mode,
  input  wire logic                    lock_en,
  input  wire logic                    lock_event_out,
  input  wire logic                    sched_en,
  input  wire logic                    tab_we,
  input  wire logic [2:0]              tab_sel,
  input  wire logic [4:0]              tab_idx,
  input  wire tmsc_pkg::tmsc_entry_type tab_data,
  output logic                         addr_match,
  output logic [7:0]                   machine_num,
  output logic                         show_num,
  output logic [7:0]                   show_value,
  output logic                         beep,
  output logic                         relay_on,
  output logic                         event_out,
  output logic                         firmware_mgmt_mode,
  output logic                         normal_mode
);
  logic [1:0]              rst_sync_q;
  logic                    rst_n;
  logic [1:0]              in_s_q;
  logic [1:0]              out_s_q;
  logic [1:0]              card_s_q;
  logic                    in_prev_q;
  tmsc_pkg::tmsc_state_type state_q;
  logic [7:0]              addr_q;
  logic [7:0]              disp_q;
  logic [31:0]             tmr_q;
  logic [31:0]             beep_q;
  logic                    ev_q;
  logic                    manual_q;
  logic [31:0]             rev_q;
  logic [ENTRIES-1:0]      bvalid_q [`TMSC_DAYS+1];
  tmsc_pkg::tmsc_time_type btime_q  [`TMSC_DAYS+1][ENTRIES];
  tmsc_pkg::tmsc_entry_type ev_tab_q [ENTRIES];
  logic                    in_press;
  logic                    sched_hit;
  logic                    sched_ev;
  logic                    sched_hold_q;
  logic [1:0]              settle_q;
  logic                    settled;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_s_q    <= 2'h0;
      out_s_q   <= 2'h0;
      card_s_q  <= 2'h0;
      in_prev_q <= 1'b0;
    end else begin
      in_s_q    <= {in_s_q[0], key_in};
      out_s_q   <= {out_s_q[0], key_out};
      card_s_q  <= {card_s_q[0], card_read};
      in_prev_q <= in_s_q[1];
    end
  end
  assign in_press = in_s_q[1] && !in_prev_q;

  // Power-up waits until both key synchronisers hold the real pin levels.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'h2) begin
      settle_q <= settle_q + 2'h1;
    end
  end
  assign settled = settle_q == 2'h2;

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tmsc_pkg::ST_POWERUP;
    end else begin
      case (state_q)
        tmsc_pkg::ST_POWERUP: begin
          if (!settled) begin
            state_q <= tmsc_pkg::ST_POWERUP;
          end else if (in_s_q[1]) begin
            state_q <= tmsc_pkg::ST_FWMGMT;
          end else if (out_s_q[1]) begin
            state_q <= tmsc_pkg::ST_WAIT;
          end else begin
            state_q <= tmsc_pkg::ST_NORMAL;
          end
        end
        tmsc_pkg::ST_WAIT: begin
          if (!out_s_q[1]) begin
            state_q <= tmsc_pkg::ST_NORMAL;
          end else if (tmr_q == 32'h0) begin
            state_q <= tmsc_pkg::ST_ADDRSET;
          end
        end
        tmsc_pkg::ST_ADDRSET: begin
          if (!out_s_q[1]) begin
            state_q <= tmsc_pkg::ST_NORMAL;
          end
        end
        tmsc_pkg::ST_NORMAL: state_q <= tmsc_pkg::ST_NORMAL;
        tmsc_pkg::ST_FWMGMT: state_q <= tmsc_pkg::ST_FWMGMT;
        default: state_q <= tmsc_pkg::ST_NORMAL;
      endcase
    end
  end

  // Shared timer: address-setting wait when key_out is held and key_in is not at power-up, otherwise the power-up display time.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= 32'h0;
    end else if (state_q == tmsc_pkg::ST_POWERUP) begin
      tmr_q <= in_s_q[1] || !out_s_q[1] ? 32'(SHOW_CYC) : 32'(SEL_CYC);
    end else if (tmr_q != 32'h0) begin
      tmr_q <= tmr_q - 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      beep_q <= 32'h0;
    end else if (state_q == tmsc_pkg::ST_WAIT && out_s_q[1] && tmr_q == 32'h0) begin
      beep_q <= 32'(BEEP_CYC);
    end else if (beep_q != 32'h0) begin
      beep_q <= beep_q - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Machine number
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disp_q <= `TMSC_ADDR_RESET;
    end else if (state_q == tmsc_pkg::ST_WAIT) begin
      disp_q <= addr_q;
    end else if (state_q == tmsc_pkg::ST_ADDRSET && in_press) begin
      disp_q <= disp_q >= `TMSC_ADDR_MAX ? 8'h00 : disp_q + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= `TMSC_ADDR_RESET;
    end else if (state_q == tmsc_pkg::ST_ADDRSET && !out_s_q[1]) begin
      addr_q <= disp_q;
    end else if (host_addr_we && state_q == tmsc_pkg::ST_NORMAL) begin
      addr_q <= host_addr;
    end
  end

  assign machine_num = addr_q;
  assign addr_match  = cmd_addr == 8'h00 || cmd_addr == addr_q;
  assign show_num    = state_q == tmsc_pkg::ST_ADDRSET || tmr_q != 32'h0 &&
                       state_q != tmsc_pkg::ST_WAIT;
  assign show_value  = state_q == tmsc_pkg::ST_ADDRSET ? disp_q : addr_q;
  assign beep        = beep_q != 32'h0;
  assign firmware_mgmt_mode = state_q == tmsc_pkg::ST_FWMGMT;
  assign normal_mode = state_q == tmsc_pkg::ST_NORMAL;

  // ----------------------------------------------------------------
  // Schedule tables
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= '{default: '0};
      btime_q  <= '{default: '{default: '0}};
      ev_tab_q <= '{default: '0};
    end else if (tab_we) begin
      if (tab_sel == 3'h7 && sched_en) begin
        ev_tab_q[tab_idx] <= tab_data;
      end else begin
        bvalid_q[tab_sel][tab_idx] <= tab_data.valid;
        btime_q[tab_sel][tab_idx]  <= tab_data.at;
      end
    end
  end

  tmsc_bell #(.ENTRIES(ENTRIES), .BELL_CYC(BELL_CYC)) u_bell (
    .clock     (clock),
    .rst_n     (rst_n),
    .week_mode (bell_week_mode),
    .weekday   (weekday),
    .now       (now),
    .day_start (day_start),
    .valid_tab (bvalid_q),
    .time_tab  (btime_q),
    .relay_on  (relay_on)
  );

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  always_comb begin
    sched_hit = 1'b0;
    sched_ev  = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (ev_tab_q[i].valid && ev_tab_q[i].at == now) begin
        sched_hit = 1'b1;
        sched_ev  = ev_tab_q[i].event_out;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ev_q     <= 1'b0;
      manual_q <= 1'b0;
      rev_q    <= 32'h0;
    end else if (state_q != tmsc_pkg::ST_NORMAL) begin
      manual_q <= 1'b0;
    end else if (in_s_q[1] || out_s_q[1]) begin
      ev_q     <= out_s_q[1];
      manual_q <= sched_en;
      rev_q    <= 32'(REVERT_CYC);
    end else if (manual_q && (card_s_q[1] || rev_q == 32'h1)) begin
      manual_q <= 1'b0;
      ev_q     <= sched_hold_q;
    end else begin
      if (rev_q != 32'h0) begin
        rev_q <= rev_q - 32'h1;
      end
      if (sched_en && sched_hit && !manual_q) begin
        ev_q <= sched_ev;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sched_hold_q <= 1'b0;
    end else if (sched_hit) begin
      sched_hold_q <= sched_ev;
    end
  end

  assign event_out = lock_en ? lock_event_out : ev_q;

  a_fw_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    firmware_mgmt_mode |=> firmware_mgmt_mode) else $error("Left firmware mode.");
  a_fw_entry: assert property (@(posedge clock) disable iff (!rst_n)
    (settled && state_q == tmsc_pkg::ST_POWERUP && in_s_q[1]) |=> firmware_mgmt_mode)
    else $error("Firmware mode missed.");
  a_norm_entry: assert property (@(posedge clock) disable iff (!rst_n)
    (settled && state_q == tmsc_pkg::ST_POWERUP && !in_s_q[1] && !out_s_q[1]) |=> normal_mode)
    else $error("Normal mode missed.");
  a_addr_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == tmsc_pkg::ST_ADDRSET && in_press && disp_q == 8'h0a && out_s_q[1])
    |=> disp_q == 8'h00) else $error("No wrap.");
  a_addr_step: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == tmsc_pkg::ST_ADDRSET && in_press && disp_q < 8'h0a)
    |=> disp_q == $past(disp_q) + 8'h01) else $error("No step.");
  a_addr_adopt: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == tmsc_pkg::ST_ADDRSET && !out_s_q[1]) |=> addr_q == $past(disp_q) && normal_mode)
    else $error("Number not adopted.");
  a_univ_addr: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_addr == 8'h00 |-> addr_match) else $error("Zero not universal.");
  a_lock_event: assert property (@(posedge clock) disable iff (!rst_n)
    lock_en |-> event_out == lock_event_out) else $error("Lock ignored.");
  c_fw: cover property (@(posedge clock) firmware_mgmt_mode);
  c_addrset: cover property (@(posedge clock) state_q == tmsc_pkg::ST_ADDRSET ##1 normal_mode);
  c_relay: cover property (@(posedge clock) relay_on);
endmodule // tmsc_ctrl

/* File: tb/tmsc_panel.sv */
// User panel model: counts beeps and measures bell relay pulses.
`timescale 1ns/10ps
module tmsc_panel (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        beep,
  input  wire logic        relay_on,
  output logic [7:0]       beep_cnt_q,
  output logic [7:0]       bell_cnt_q,
  output logic [15:0]      bell_len_q
);
  logic        beep_q;
  logic        relay_q;
  logic [15:0] run_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      beep_q     <= 1'b0;
      beep_cnt_q <= 8'h00;
    end else begin
      beep_q <= beep;
      if (beep && !beep_q) begin
        beep_cnt_q <= beep_cnt_q + 8'h01;
      end
    end
  end

  // A pulse length is latched when the relay drops, so it measures the whole pulse.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      relay_q    <= 1'b0;
      run_q      <= 16'h0000;
      bell_cnt_q <= 8'h00;
      bell_len_q <= 16'h0000;
    end else begin
      relay_q <= relay_on;
      if (relay_on) begin
        run_q <= run_q + 16'h0001;
      end else begin
        run_q <= 16'h0000;
      end
      if (relay_on && !relay_q) begin
        bell_cnt_q <= bell_cnt_q + 8'h01;
      end
      if (!relay_on && relay_q) begin
        bell_len_q <= run_q;
      end
    end
  end
endmodule // tmsc_panel

/* File: tb/tmsc_ctrl_test.sv */
// Self-checking bench for the terminal mode and schedule controller.
`timescale 1ns/10ps
module tmsc_ctrl_test;
  localparam int SEL  = 20;
  localparam int REV  = 20;
  localparam int BELL = 6;
  logic                     clock = 1'b0;
  logic                     reset_n = 1'b0;
  logic                     key_in = 1'b0;
  logic                     key_out = 1'b0;
  logic                     card_read = 1'b0;
  logic                     host_addr_we = 1'b0;
  logic [7:0]               host_addr = 8'h00;
  logic [7:0]               cmd_addr = 8'h00;
  tmsc_pkg::tmsc_time_type  now = '0;
  logic [2:0]               weekday = 3'h0;
  logic                     day_start = 1'b0;
  logic                     bell_week_mode = 1'b0;
  logic                     lock_en = 1'b0;
  logic                     lock_event_out = 1'b0;
  logic                     sched_en = 1'b0;
  logic                     tab_we = 1'b0;
  logic [2:0]               tab_sel = 3'h0;
  logic [4:0]               tab_idx = 5'h00;
  tmsc_pkg::tmsc_entry_type tab_data = '0;
  logic                     addr_match;
  logic [7:0]               machine_num;
  logic                     show_num;
  logic [7:0]               show_value;
  logic                     beep;
  logic                     relay_on;
  logic                     event_out;
  logic                     firmware_mgmt_mode;
  logic                     normal_mode;
  logic [7:0]               beep_cnt;
  logic [7:0]               bell_cnt;
  logic [15:0]              bell_len;
  int                       mismatches = 0;
  int                       cmp_count = 0;

  always #20 clock = ~clock;

  tmsc_ctrl #(.SEL_CYC(SEL), .REVERT_CYC(REV), .SHOW_CYC(20), .BEEP_CYC(4),
    .BELL_CYC(BELL)) u_dut (.clock, .reset_n, .key_in, .key_out, .card_read,
    .host_addr_we, .host_addr, .cmd_addr, .now, .weekday, .day_start, .bell_week_mode,
    .lock_en, .lock_event_out, .sched_en, .tab_we, .tab_sel, .tab_idx, .tab_data,
    .addr_match, .machine_num, .show_num, .show_value, .beep, .relay_on, .event_out,
    .firmware_mgmt_mode, .normal_mode);

  tmsc_panel u_panel (.clock, .reset_n, .beep, .relay_on, .beep_cnt_q(beep_cnt),
    .bell_cnt_q(bell_cnt), .bell_len_q(bell_len));

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic power_up(input logic ki, input logic ko);
    reset_n = 1'b0;
    key_in  = ki;
    key_out = ko;
    tick(8);
    reset_n = 1'b1;
    tick(8);
  endtask

  task automatic wr_tab(input logic [2:0] sel, input logic [4:0] idx, input logic [4:0] h,
                        input logic [5:0] m, input logic ev);
    tab_sel  = sel;
    tab_idx  = idx;
    tab_data = {1'b1, h, m, ev};
    tab_we   = 1'b1;
    tick(1);
    tab_we   = 1'b0;
    tick(1);
  endtask

  task automatic host_wr(input logic [7:0] a);
    host_addr    = a;
    host_addr_we = 1'b1;
    tick(1);
    host_addr_we = 1'b0;
    tick(2);
  endtask

  task automatic match(input logic [7:0] a, input logic exp);
    cmd_addr = a;
    #1;
    check(addr_match, exp);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop;
  end

  initial begin
    power_up(1'b0, 1'b0);
    check(normal_mode, 1'b1);
    check(firmware_mgmt_mode, 1'b0);
    check({show_num, show_value}, 9'h100);
    tick(30);
    check(show_num, 1'b0);
    host_wr(8'h19);
    check(machine_num, 8'h19);
    match(8'h00, 1'b1);
    match(8'h19, 1'b1);
    match(8'h18, 1'b0);
    host_wr(8'hff);
    check(machine_num, 8'hff);
    match(8'hff, 1'b1);
    match(8'h00, 1'b1);
    $display("test address done");

    power_up(1'b1, 1'b0);
    check(firmware_mgmt_mode, 1'b1);
    check(normal_mode, 1'b0);
    key_in = 1'b0;
    host_wr(8'h05);
    tick(40);
    check(firmware_mgmt_mode, 1'b1);
    check(machine_num, 8'h00);
    power_up(1'b1, 1'b1);
    check(firmware_mgmt_mode, 1'b1);
    $display("test firmware mode done");

    power_up(1'b0, 1'b1);
    check(normal_mode, 1'b0);
    tick(SEL + 8);
    check(beep_cnt, 8'h01);
    check(show_value, 8'h00);
    for (int i = 1; i <= 14; i++) begin
      key_in = 1'b1;
      tick(6);
      key_in = 1'b0;
      tick(6);
      check(show_value, 8'(i % 11));
    end
    key_out = 1'b0;
    tick(8);
    check(machine_num, 8'h03);
    check(normal_mode, 1'b1);
    $display("test address setting done");

    wr_tab(3'h7, 5'h05, 5'd8, 6'd0, 1'b0);
    wr_tab(3'h7, 5'h1f, 5'd8, 6'd1, 1'b0);
    now = {5'd8, 6'd0};
    tick(BELL + 10);
    check(bell_cnt, 8'h01);
    check(bell_len, 16'(BELL));
    tick(20);
    check(bell_cnt, 8'h01);
    day_start = 1'b1;
    tick(1);
    day_start = 1'b0;
    tick(BELL + 10);
    check(bell_cnt, 8'h02);
    now = {5'd8, 6'd1};
    tick(BELL + 10);
    check(bell_cnt, 8'h03);
    bell_week_mode = 1'b1;
    wr_tab(3'h2, 5'h00, 5'd9, 6'd0, 1'b0);
    weekday = 3'h3;
    now = {5'd9, 6'd0};
    tick(20);
    check(bell_cnt, 8'h03);
    weekday = 3'h2;
    tick(BELL + 10);
    check(bell_cnt, 8'h04);
    check(bell_len, 16'(BELL));
    $display("test bell done");

    now = {5'd12, 6'd0};
    key_out = 1'b1;
    tick(8);
    check(event_out, 1'b1);
    key_out = 1'b0;
    key_in = 1'b1;
    tick(8);
    check(event_out, 1'b0);
    lock_en = 1'b1;
    lock_event_out = 1'b1;
    tick(8);
    check(event_out, 1'b1);
    key_in = 1'b0;
    lock_en = 1'b0;
    tick(4);
    check(event_out, 1'b0);
    sched_en = 1'b1;
    wr_tab(3'h7, 5'h03, 5'd10, 6'd0, 1'b1);
    now = {5'd10, 6'd0};
    tick(8);
    check(event_out, 1'b1);
    key_in = 1'b1;
    tick(8);
    key_in = 1'b0;
    check(event_out, 1'b0);
    tick(REV + 10);
    check(event_out, 1'b1);
    key_in = 1'b1;
    tick(8);
    key_in = 1'b0;
    card_read = 1'b1;
    tick(4);
    card_read = 1'b0;
    tick(6);
    check(event_out, 1'b1);
    $display("test event selection done");
    report_and_stop;
  end
endmodule // tmsc_ctrl_test
